// file: rtl/tv_std_pkg.sv
// constants, field layout and carrier types of the tv standard control registers
package tv_std_pkg;

    localparam int DATA_W = 12;
    localparam int ADDR_W = 10;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_HUE = 8'h1c;
    localparam logic [7:0] IDX_CHROMA = 8'ha0;
    localparam logic [7:0] IDX_VLOCK = 8'he7;
    localparam logic [7:0] IDX_STDCTL = 8'hf2;
    localparam logic [7:0] IDX_STDSTAT = 8'hf3;

    // standard control word fields
    localparam int CTL_MANUAL_BIT = 0;
    localparam int CTL_STD_LSB = 1;
    localparam int CTL_LATCH_BIT = 4;
    localparam int CTL_SVIDEO_BIT = 5;
    localparam int CTL_THR_LSB = 6;

    // standard status word fields
    localparam int STAT_SUPP_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_STD_LSB = 2;
    localparam int STAT_NOVID_BIT = 5;
    localparam int STAT_CONF_LSB = 6;
    localparam int STAT_LINE_BIT = 10;

    // vertical lock control word fields
    localparam int VL_EN_BIT = 0;
    localparam int VL_LINES_LSB = 1;

    // common 3-bit standard encoding
    localparam logic [2:0] STD_PAL_BGHI = 3'h0;
    localparam logic [2:0] STD_NTSC_M = 3'h1;
    localparam logic [2:0] STD_SECAM = 3'h2;
    localparam logic [2:0] STD_NTSC_44 = 3'h3;
    localparam logic [2:0] STD_PAL_M = 3'h4;
    localparam logic [2:0] STD_PAL_N = 3'h5;
    localparam logic [2:0] STD_PAL_60 = 3'h6;
    localparam logic [2:0] STD_NTSC_COMB = 3'h7;

    // reset values
    localparam logic [3:0] RST_THRESHOLD = 4'hf;
    localparam logic [2:0] RST_STD = 3'h0;
    localparam logic [11:0] RST_HUE = 12'h000;
    localparam logic [11:0] RST_CHROMA = 12'h000;
    localparam logic [10:0] RST_VL_LINES = 11'h000;

    // chroma gain reference special values
    localparam logic [11:0] CHROMA_AUTO_GAIN_OFF = 12'h000;
    localparam logic [11:0] CHROMA_MIN_SAT = 12'h001;

    // recognition engine report
    typedef struct packed {
        logic active_video_suppressed;
        logic running;
        logic [2:0] std;
        logic no_video;
        logic [3:0] confidence;
    } recog_t;

    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage

// file: rtl/tv_standard_control_regs.sv
// tv standard selection, recognition status, vertical lock and colour registers
//
// What this block does
// - all standard fields share one 3-bit code covering eight standards
// - codes 000, 010, 101 are 625/50; the rest 525/60; 111 comb NTSC
// - control bit 0 picks automatic (0) or manual (1) standard choice
// - control bits 3..1 hold the manual standard code
// - control bit 4 written 1 together with bit 0 latches manual standard, then clears itself
// - control bit 5 picks composite (0) or separated luma/chroma (1) input
// - control bits 9..6 set search score threshold, default 1111
// - status bit 0 reports active video indicator suppressed (1) or enabled
// - status bit 1 reads 1 while recognition runs, 0 when idle
// - status bits 4..2 report the detected standard code
// - status bit 5 reads 1 when no video at selected input
// - status bits 9..6 report highest recognition confidence score
// - status bit 10 gives detected line standard, 1 means 625/50
// - vertical lock bit 0 enables vertical standard locking
// - vertical lock bits 11..1 hold expected lines per field
// - hue rotation is signed tint angle, 512 equals a quarter pi
// - chroma gain reference sets saturation; zero turns auto gain off
// - chroma gain reference of one gives minimal saturation, colour off
`timescale 1ns/10ps
module tv_standard_control_regs
    import tv_std_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // recognition engine report
    input wire recog_t i_recog,
    // standard selection
    output logic o_manual_sel,
    output logic [2:0] o_active_std,
    output logic o_active_line_625,
    output logic o_std_latch,
    output logic o_std_changed,
    output logic o_svideo_sel,
    output logic [3:0] o_score_threshold,
    output logic o_search_accept,
    // vertical locking
    output logic o_vlock_en,
    output logic [10:0] o_lines_per_field,
    // colour processing
    output logic [11:0] o_hue_rotation,
    output logic [11:0] o_chroma_gain_reference,
    output logic o_auto_chroma_gain_en,
    output logic o_colour_off
);

    typedef struct packed {
        bus_state_t bus;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
        logic manual;
        logic [2:0] manual_std;
        logic [2:0] latched_std;
        logic latch_pulse;
        logic svideo;
        logic [3:0] thr;
        logic [2:0] active_std;
        logic line_625;
        logic std_change;
        logic accept;
        logic vl_en;
        logic [10:0] vl_lines;
        logic [11:0] hue;
        logic [11:0] chroma;
        logic auto_gain_en;
        logic colour_off;
    } state_t;

    state_t state_q;
    state_t state_d;

    // byte address of a register index
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    function automatic logic is_625(input logic [2:0] code);
        case (code)
            STD_PAL_BGHI: is_625 = 1'b1;
            STD_NTSC_M: is_625 = 1'b0;
            STD_SECAM: is_625 = 1'b1;
            STD_NTSC_44: is_625 = 1'b0;
            STD_PAL_M: is_625 = 1'b0;
            STD_PAL_N: is_625 = 1'b1;
            STD_PAL_60: is_625 = 1'b0;
            STD_NTSC_COMB: is_625 = 1'b0;
            default: is_625 = 1'b0;
        endcase
    endfunction

    // byte lanes 0 and 1 carry the 12-bit word
    function automatic logic [11:0] merge(input logic [11:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [11:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[11:8] = wd[11:8];
        end
        merge = r;
    endfunction

    logic [11:0] status_word;
    logic [11:0] ctl_word;
    logic [11:0] vl_word;
    logic [2:0] applied_std;
    logic auto_ok;

    always_comb begin
        status_word = 12'h000;
        status_word[STAT_SUPP_BIT] = i_recog.active_video_suppressed;
        status_word[STAT_RUN_BIT] = i_recog.running;
        status_word[STAT_STD_LSB +: 3] = i_recog.std;
        status_word[STAT_NOVID_BIT] = i_recog.no_video;
        status_word[STAT_CONF_LSB +: 4] = i_recog.confidence;
        status_word[STAT_LINE_BIT] = is_625(i_recog.std);
    end

    always_comb begin
        state_d = state_q;
        state_d.latch_pulse = 1'b0;
        state_d.std_change = 1'b0;
        ctl_word = 12'h000;
        vl_word = 12'h000;

        case (state_q.bus)
            BUS_IDLE: begin
                // answer one cycle after the request is seen
                if (i_avs_read || i_avs_write) begin
                    state_d.bus = BUS_ACK;
                    state_d.waitreq = 1'b0;
                    state_d.rdata = 12'h000;
                    if (i_avs_read) begin
                        if (hit(i_avs_address, IDX_HUE)) begin
                            state_d.rdata = state_q.hue;
                        end else if (hit(i_avs_address, IDX_CHROMA)) begin
                            state_d.rdata = state_q.chroma;
                        end else if (hit(i_avs_address, IDX_STDSTAT)) begin
                            state_d.rdata = status_word;
                        end
                    end
                end
            end
            BUS_ACK: begin
                // write lands at the edge that samples waitrequest low
                state_d.bus = BUS_IDLE;
                state_d.waitreq = 1'b1;
                if (i_avs_write) begin
                    if (hit(i_avs_address, IDX_HUE)) begin
                        state_d.hue = merge(state_q.hue, i_avs_writedata, i_avs_byteenable);
                    end
                    if (hit(i_avs_address, IDX_CHROMA)) begin
                        state_d.chroma = merge(state_q.chroma, i_avs_writedata,
                                               i_avs_byteenable);
                    end
                    if (hit(i_avs_address, IDX_VLOCK)) begin
                        vl_word = merge({state_q.vl_lines, state_q.vl_en},
                                        i_avs_writedata, i_avs_byteenable);
                        state_d.vl_en = vl_word[VL_EN_BIT];
                        state_d.vl_lines = vl_word[VL_LINES_LSB +: 11];
                    end
                    if (hit(i_avs_address, IDX_STDCTL)) begin
                        // reserved bits 11..10 are dropped, software keeps them zero
                        ctl_word = merge({2'b00, state_q.thr, state_q.svideo, 1'b0,
                                          state_q.manual_std, state_q.manual},
                                         i_avs_writedata, i_avs_byteenable);
                        state_d.manual = ctl_word[CTL_MANUAL_BIT];
                        state_d.manual_std = ctl_word[CTL_STD_LSB +: 3];
                        state_d.svideo = ctl_word[CTL_SVIDEO_BIT];
                        state_d.thr = ctl_word[CTL_THR_LSB +: 4];
                        // strobe is never stored, so it reads back as cleared
                        if (ctl_word[CTL_LATCH_BIT] && ctl_word[CTL_MANUAL_BIT]) begin
                            state_d.latched_std = ctl_word[CTL_STD_LSB +: 3];
                            state_d.latch_pulse = 1'b1;
                        end
                    end
                end
            end
            default: begin
                state_d.bus = BUS_IDLE;
                state_d.waitreq = 1'b1;
            end
        endcase

        // automatic result only taken when recognition settled at or above threshold
        auto_ok = !i_recog.running && !i_recog.no_video
                  && (i_recog.confidence >= state_q.thr);
        state_d.accept = auto_ok;
        applied_std = state_q.active_std;
        if (state_q.manual) begin
            applied_std = state_q.latched_std;
        end else if (auto_ok) begin
            applied_std = i_recog.std;
        end
        state_d.active_std = applied_std;
        state_d.line_625 = is_625(applied_std);
        state_d.std_change = (applied_std != state_q.active_std);

        state_d.auto_gain_en = (state_q.chroma != CHROMA_AUTO_GAIN_OFF);
        state_d.colour_off = (state_q.chroma == CHROMA_MIN_SAT);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q.bus <= BUS_IDLE;
            state_q.waitreq <= 1'b1;
            state_q.rdata <= 12'h000;
            state_q.manual <= 1'b0;
            state_q.manual_std <= RST_STD;
            state_q.latched_std <= RST_STD;
            state_q.latch_pulse <= 1'b0;
            state_q.svideo <= 1'b0;
            state_q.thr <= RST_THRESHOLD;
            state_q.active_std <= RST_STD;
            state_q.line_625 <= 1'b1;
            state_q.std_change <= 1'b0;
            state_q.accept <= 1'b0;
            state_q.vl_en <= 1'b0;
            state_q.vl_lines <= RST_VL_LINES;
            state_q.hue <= RST_HUE;
            state_q.chroma <= RST_CHROMA;
            state_q.auto_gain_en <= 1'b0;
            state_q.colour_off <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_avs_readdata = {20'h00000, state_q.rdata};
    assign o_avs_waitrequest = state_q.waitreq;
    assign o_manual_sel = state_q.manual;
    assign o_active_std = state_q.active_std;
    assign o_active_line_625 = state_q.line_625;
    assign o_std_latch = state_q.latch_pulse;
    assign o_std_changed = state_q.std_change;
    assign o_svideo_sel = state_q.svideo;
    assign o_score_threshold = state_q.thr;
    assign o_search_accept = state_q.accept;
    assign o_vlock_en = state_q.vl_en;
    assign o_lines_per_field = state_q.vl_lines;
    assign o_hue_rotation = state_q.hue;
    assign o_chroma_gain_reference = state_q.chroma;
    assign o_auto_chroma_gain_en = state_q.auto_gain_en;
    assign o_colour_off = state_q.colour_off;

endmodule

// file: dv/tv_standard_control_regs_chk.sv
// port assertions for the tv standard control registers
`timescale 1ns/10ps
module tv_standard_control_regs_chk
    import tv_std_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register bus
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // standard and colour
    input wire recog_t i_recog,
    input wire logic o_manual_sel,
    input wire logic [2:0] o_active_std,
    input wire logic o_active_line_625,
    input wire logic o_std_latch,
    input wire logic o_std_changed,
    input wire logic o_svideo_sel,
    input wire logic [3:0] o_score_threshold,
    input wire logic o_search_accept,
    input wire logic [11:0] o_hue_rotation,
    input wire logic [11:0] o_chroma_gain_reference,
    input wire logic o_auto_chroma_gain_en,
    input wire logic o_colour_off
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    recog_t rq;
    logic st_rd, ctl_wr, hue_wr;
    function automatic logic is625(input logic [2:0] s);
        return s == 3'h0 || s == 3'h2 || s == 3'h5;
    endfunction
    // status is captured on the edge that takes the read
    always_ff @(posedge i_clk) rq <= i_recog;
    assign st_rd = i_avs_read && o_avs_waitrequest && i_avs_address == {IDX_STDSTAT, 2'h0};
    assign ctl_wr = i_avs_write && o_avs_waitrequest && i_avs_byteenable[1:0] == 2'h3
        && i_avs_address == {IDX_STDCTL, 2'h0};
    assign hue_wr = i_avs_write && o_avs_waitrequest && i_avs_byteenable[1:0] == 2'h3
        && i_avs_address == {IDX_HUE, 2'h0};
    AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("no answer one cycle after request");
    AST_WAIT_PULSE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_STATUS: assert property (st_rd |=> o_avs_readdata == {21'h0, is625(rq.std),
        rq.confidence, rq.no_video, rq.std, rq.running, rq.active_video_suppressed})
        else $error("status word mismatch");
    AST_LATCH: assert property (ctl_wr && i_avs_writedata[4] && i_avs_writedata[0]
        |-> ##2 o_std_latch ##1 o_active_std == $past(i_avs_writedata[3:1], 3))
        else $error("manual latch not applied");
    AST_AUTO_NOLATCH: assert property (ctl_wr && !i_avs_writedata[0] |-> ##2 !o_std_latch)
        else $error("latch accepted in automatic mode");
    AST_CTL: assert property (ctl_wr |-> ##2 {o_score_threshold, o_svideo_sel, o_manual_sel}
        == {$past(i_avs_writedata[9:5], 2), $past(i_avs_writedata[0], 2)})
        else $error("control fields mismatch");
    AST_LINE: assert property (o_active_line_625 == is625(o_active_std))
        else $error("line standard mismatch");
    // change pulse is registered together with the new standard
    AST_CHANGED: assert property (o_std_changed == $changed(o_active_std))
        else $error("no change pulse");
    AST_AUTO_GAIN: assert property ($past(i_rst_n) |-> o_auto_chroma_gain_en
        == ($past(o_chroma_gain_reference) != 12'h000))
        else $error("auto chroma gain enable mismatch");
    AST_COLOUR: assert property ($past(i_rst_n) |-> o_colour_off
        == ($past(o_chroma_gain_reference) == 12'h001)) else $error("colour off mismatch");
    AST_ACCEPT: assert property ($past(i_rst_n) |-> o_search_accept == $past(!i_recog.running
        && !i_recog.no_video && i_recog.confidence >= o_score_threshold))
        else $error("search accept mismatch");
    AST_HUE: assert property (hue_wr |-> ##2 o_hue_rotation == $past(i_avs_writedata[11:0], 2))
        else $error("hue mismatch");
    cover property (st_rd);
    cover property (o_std_latch);
    cover property (o_search_accept);
endmodule
bind tv_standard_control_regs tv_standard_control_regs_chk chk_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_recog(i_recog), .o_manual_sel(o_manual_sel),
    .o_active_std(o_active_std), .o_active_line_625(o_active_line_625),
    .o_std_latch(o_std_latch), .o_std_changed(o_std_changed), .o_svideo_sel(o_svideo_sel),
    .o_score_threshold(o_score_threshold), .o_search_accept(o_search_accept),
    .o_hue_rotation(o_hue_rotation), .o_chroma_gain_reference(o_chroma_gain_reference),
    .o_auto_chroma_gain_en(o_auto_chroma_gain_en), .o_colour_off(o_colour_off));

// file: dv/tb_top.sv
// self-checking bench for the tv standard control registers
`timescale 1ns/10ps
module tb_top
    import tv_std_pkg::*;
;
    logic i_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [ADDR_W-1:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, r;
    logic [3:0] i_avs_byteenable, o_score_threshold;
    recog_t i_recog;
    logic o_manual_sel, o_active_line_625, o_std_latch, o_std_changed, o_svideo_sel;
    logic o_search_accept, o_vlock_en, o_auto_chroma_gain_en, o_colour_off;
    logic [2:0] o_active_std;
    logic [10:0] o_lines_per_field;
    logic [11:0] o_hue_rotation, o_chroma_gain_reference, d, v;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    localparam logic [9:0] A_HUE = {IDX_HUE, 2'h0};
    localparam logic [9:0] A_CHR = {IDX_CHROMA, 2'h0};
    localparam logic [9:0] A_VL = {IDX_VLOCK, 2'h0};
    localparam logic [9:0] A_CTL = {IDX_STDCTL, 2'h0};
    localparam logic [9:0] A_STAT = {IDX_STDSTAT, 2'h0};
    logic [9:0] wo[3] = '{A_CTL, A_VL, 10'h004};
    // recognition report and expected standard/accept
    logic [13:0] av[3] = '{{10'h069, 4'h7}, {10'h0a7, 4'h6}, {10'h0c8, 4'hd}};
    wire [9:0] ctl_view = {o_score_threshold, o_svideo_sel, o_manual_sel, o_active_std,
        o_active_line_625};
    tv_standard_control_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_recog(i_recog), .o_manual_sel(o_manual_sel), .o_active_std(o_active_std),
        .o_active_line_625(o_active_line_625), .o_std_latch(o_std_latch),
        .o_std_changed(o_std_changed), .o_svideo_sel(o_svideo_sel),
        .o_score_threshold(o_score_threshold), .o_search_accept(o_search_accept),
        .o_vlock_en(o_vlock_en), .o_lines_per_field(o_lines_per_field),
        .o_hue_rotation(o_hue_rotation), .o_chroma_gain_reference(o_chroma_gain_reference),
        .o_auto_chroma_gain_en(o_auto_chroma_gain_en), .o_colour_off(o_colour_off));
    function automatic logic ln(input int s);
        return s == 0 || s == 2 || s == 5;
    endfunction
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is sampled low; a hang ends at the global timeout
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] dt,
        input logic [3:0] be);
        @(posedge i_clk);
        i_avs_read <= !wr;
        i_avs_write <= wr;
        i_avs_address <= a;
        i_avs_writedata <= dt;
        i_avs_byteenable <= be;
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        r = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic w;
        repeat (6) @(posedge i_clk);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        {i_rst_n, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
        i_avs_byteenable = '0;
        i_recog = '0;
        r = $urandom(32'h367f15cc);
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        chk({o_score_threshold, o_active_std, o_active_line_625}, 8'hf1);
        foreach (wo[i]) begin
            bus(1'b0, wo[i], '0, 4'h3);
            chk(r, 32'h0);
        end
        $display("reset test done");
        for (int s = 0; s < 8; s++) begin
            v = 12'($urandom);
            v[7:5] = s[2:0];
            i_recog <= v[9:0];
            bus(1'b0, A_STAT, '0, 4'h3);
            chk(r, {21'h0, ln(s), v[3:0], v[4], v[7:5], v[8], v[9]});
        end
        $display("status test done");
        for (int k = 0; k < 4; k++) begin
            v = (k < 2) ? 12'(k) : 12'($urandom);
            bus(1'b1, A_CHR, {20'h0, v}, 4'h3);
            bus(1'b0, A_CHR, '0, 4'h3);
            chk(r, {20'h0, v});
            w();
            chk({o_auto_chroma_gain_en, o_colour_off}, {v != 0, v == 1});
        end
        d = 12'($urandom);
        v = 12'($urandom);
        bus(1'b1, A_HUE, {20'h0, d}, 4'h3);
        bus(1'b1, A_HUE, {20'h0, v}, 4'h1);
        bus(1'b0, A_HUE, '0, 4'h3);
        chk(r, {20'h0, d[11:8], v[7:0]});
        chk(o_hue_rotation, {d[11:8], v[7:0]});
        d = 12'($urandom);
        bus(1'b1, A_VL, {20'h0, d}, 4'h3);
        w();
        chk({o_lines_per_field, o_vlock_en}, d);
        $display("colour and lock test done");
        for (int s = 0; s < 8; s++) begin
            v = 12'($urandom);
            d = {2'h0, v[3:0], v[4], 1'b1, s[2:0], 1'b1};
            bus(1'b1, A_CTL, {20'h0, d}, 4'h3);
            w();
            chk(ctl_view, {d[9:5], 1'b1, s[2:0], ln(s)});
        end
        bus(1'b1, A_CTL, 32'h3c5, 4'h3);
        w();
        chk(ctl_view, 10'h3de);
        $display("manual test done");
        bus(1'b1, A_CTL, 32'h200, 4'h3);
        foreach (av[i]) begin
            i_recog <= av[i][13:4];
            w();
            chk({o_active_std, o_search_accept}, av[i][3:0]);
        end
        bus(1'b1, A_CTL, 32'h212, 4'h3);
        w();
        chk({o_active_std, o_search_accept}, 4'hd);
        $display("automatic test done");
        give_verdict();
    end
endmodule
